// ==== logic/irq_rst_pkg.sv ====
// Purpose: Shared constants and types for the pin request and reset cause
//          register block.
// Assumes: 8-bit registers in the low byte of a 32-bit Avalon word.
// Notes:   Offsets are byte addresses on the Avalon slave.
package irq_rst_pkg;
  localparam int          REG_W      = 8;
  localparam int          AVS_ADDR_W = 4;
  localparam logic [3:0]  OFS_PIN_CTRL     = 4'h0;
  localparam logic [3:0]  OFS_RESET_STATUS = 4'h4;

  // Pin control field positions
  localparam int PC_EDGE = 5;
  localparam int PC_PE   = 4;
  localparam int PC_FLAG = 3;
  localparam int PC_ACK  = 2;
  localparam int PC_IE   = 1;
  localparam int PC_MOD  = 0;

  // Reset cause field positions
  localparam int RS_POR  = 7;
  localparam int RS_PIN  = 6;
  localparam int RS_WDOG = 5;
  localparam int RS_OPC  = 4;
  localparam int RS_ADR  = 3;
  localparam int RS_CLK  = 2;
  localparam int RS_LVD  = 1;

  localparam logic [7:0]  STATUS_CLEAR   = 8'h00;
  localparam logic [7:0]  POR_STATUS     = 8'h82;
  localparam logic        PIN_IDLE_LEVEL = 1'b1;

  // Illegal address gaps
  localparam logic [15:0] GAP0_LO = 16'h0880;
  localparam logic [15:0] GAP0_HI = 16'h17FF;
  localparam logic [15:0] GAP1_LO = 16'h182C;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  typedef struct packed {
    bus_state_t  bus;
    logic [31:0] rdata;
    logic        edge_sel;
    logic        pin_en;
    logic        flag;
    logic        irq_en;
    logic        mode;
    logic        pin_prev;
    logic        irq;
    logic        wdog_restart;
    logic [7:0]  status;
  } blk_state_t;
endpackage

// ==== logic/irq_pin_and_reset_status.sv ====
// Purpose: Pin request control register and reset cause status register
//          on an Avalon-MM slave with waitrequest.
// Assumes: Pin and source inputs are synchronous to i_core_clk; reset
//          sources hold their level while i_rst is high.
// Notes:   Every access takes two cycles; waitrequest drops in the second.
// Function
// (RQ1) Polarity bit 5: 0 falling/low, 1 rising/high sets the event flag.
// (RQ2) Pin enabled with rising polarity turns pull resistor into pull-down.
// (RQ3) Pin enable bit 4 gates pin as request source and enables pull.
// (RQ4) Read-only flag bit 3 sets on a qualifying event, else reads 0.
// (RQ5) Writing 1 to acknowledge bit 2 clears flag; bit reads 0.
// (RQ6) Edge-and-level mode: acknowledge cannot clear while pin stays asserted.
// (RQ7) Interrupt enable bit 1 drives request whenever flag is 1.
// (RQ8) Mode bit 0: 0 edges only, 1 edges plus matching level.
// (RQ9) Two unimplemented control bits read 0 and ignore writes.
// (RQ10) Debug forced reset leaves every cause bit cleared.
// (RQ11) Any write to status address restarts watchdog, contents kept.
// (RQ12) Power-on reset sets bits 7 and 1, clears the rest.
// (RQ13) Low-voltage reset sets bit 1, clears others, keeps bit 7.
// (RQ14) Each cause bit follows whether its source is active at reset.
// (RQ15) Bit 6 marks a reset from the external reset pin.
// (RQ16) Bit 5 marks watchdog timeout; blocked while watchdog disabled.
// (RQ17) Bit 4 marks bad opcodes, disabled stop or background entry.
// (RQ18) Bit 3 marks accesses inside the two illegal address gaps.
// (RQ19) Reserved locations within register areas never count as illegal.
// (RQ20) Bit 2 marks a reset from the clock generation module.
// (RQ21) Brownout reset needs both enables and low supply; stop gates it.
// (RQ22) Status bit 0 reads 0; all cause bits read-only.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module irq_pin_and_reset_status
  import irq_rst_pkg::*;
#(
  parameter int          DATA_W  = 32,
  parameter logic [15:0] GAP1_HI = 16'hBFFF
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic [AVS_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [DATA_W-1:0]     i_avs_writedata,
  input  wire logic [DATA_W/8-1:0]   i_avs_byteenable,
  output logic      [DATA_W-1:0]     o_avs_readdata,
  output logic                       o_avs_waitrequest,
  input  wire logic                  i_irq_pin,
  output logic                       o_irq_request,
  output logic                       o_pull_enable,
  output logic                       o_pull_down,
  output logic                       o_watchdog_restart,
  output logic                       o_reset_request,
  input  wire logic                  i_power_on,
  input  wire logic                  i_ext_reset_pin_n,
  input  wire logic                  i_watchdog_timeout,
  input  wire logic                  i_watchdog_enable_setting,
  input  wire logic                  i_illegal_opcode,
  input  wire logic                  i_stop_instr,
  input  wire logic                  i_stop_allowed_setting,
  input  wire logic                  i_background_entry_instruction,
  input  wire logic                  i_background_allowed_setting,
  input  wire logic                  i_access_valid,
  input  wire logic [15:0]           i_access_addr,
  input  wire logic                  i_access_in_register_area,
  input  wire logic                  i_clock_gen_reset,
  input  wire logic                  i_supply_low,
  input  wire logic                  i_stop_mode,
  input  wire logic                  i_brownout_detect_enable,
  input  wire logic                  i_brownout_reset_enable,
  input  wire logic                  i_brownout_in_stop_enable,
  input  wire logic                  i_debug_forced_reset_bit
);

  if (DATA_W != 32) begin : g_bad_width
    $error("DATA_W must be 32");
  end
  if (GAP1_HI < GAP1_LO) begin : g_bad_gap
    $error("GAP1_HI below GAP1_LO");
  end

  blk_state_t s_q;
  blk_state_t s_d;

  logic       req;
  logic       accept;
  logic       sel_ctrl;
  logic       sel_status;
  logic       wr_ctrl;
  logic       pin_rise;
  logic       pin_fall;
  logic       edge_hit;
  logic       level_hit;
  logic       event_hit;
  logic       wdog_cause;
  logic       opc_cause;
  logic       adr_cause;
  logic       lvd_cause;
  logic [7:0] ctrl_image;
  logic [7:0] status_cap;

  // Bus handshake
  assign req        = i_avs_read | i_avs_write;
  assign accept     = req & (s_q.bus == BUS_ACK);
  assign o_avs_waitrequest = req & (s_q.bus != BUS_ACK);
  assign sel_ctrl   = (i_avs_address == OFS_PIN_CTRL);
  assign sel_status = (i_avs_address == OFS_RESET_STATUS);
  // Low byte lane carries the register
  assign wr_ctrl    = accept & i_avs_write & sel_ctrl & i_avs_byteenable[0];

  // Pin event detection
  assign pin_rise  = i_irq_pin & ~s_q.pin_prev;
  assign pin_fall  = ~i_irq_pin & s_q.pin_prev;
  assign edge_hit  = s_q.edge_sel ? pin_rise : pin_fall; // RQ1
  assign level_hit = (i_irq_pin == s_q.edge_sel); // RQ1
  assign event_hit = s_q.pin_en & (edge_hit | (s_q.mode & level_hit)); // RQ3 RQ8

  // Unimplemented and acknowledge bits read 0
  always_comb begin
    ctrl_image          = 8'h00; // RQ9 RQ5
    ctrl_image[PC_EDGE] = s_q.edge_sel;
    ctrl_image[PC_PE]   = s_q.pin_en;
    ctrl_image[PC_FLAG] = s_q.flag; // RQ4
    ctrl_image[PC_IE]   = s_q.irq_en;
    ctrl_image[PC_MOD]  = s_q.mode;
  end

  // Qualified reset sources
  assign wdog_cause = i_watchdog_timeout & i_watchdog_enable_setting; // RQ16
  assign opc_cause  = i_illegal_opcode
                    | (i_stop_instr & ~i_stop_allowed_setting)
                    | (i_background_entry_instruction
                       & ~i_background_allowed_setting); // RQ17
  assign adr_cause  = i_access_valid & ~i_access_in_register_area // RQ19
                    & (((i_access_addr >= GAP0_LO)
                        & (i_access_addr <= GAP0_HI))
                       | ((i_access_addr >= GAP1_LO)
                          & (i_access_addr <= GAP1_HI))); // RQ18
  assign lvd_cause  = i_supply_low & i_brownout_detect_enable
                    & i_brownout_reset_enable
                    & (~i_stop_mode | i_brownout_in_stop_enable); // RQ21

  // Cause image captured while reset is held
  always_comb begin
    status_cap = STATUS_CLEAR;
    if (i_debug_forced_reset_bit) begin
      status_cap = STATUS_CLEAR; // RQ10
    end else if (i_power_on) begin
      status_cap = POR_STATUS; // RQ12
    end else if (lvd_cause) begin
      status_cap[RS_LVD] = 1'b1; // RQ13
      status_cap[RS_POR] = s_q.status[RS_POR]; // RQ13
    end else begin
      status_cap[RS_PIN]  = ~i_ext_reset_pin_n; // RQ14 RQ15
      status_cap[RS_WDOG] = wdog_cause; // RQ14
      status_cap[RS_OPC]  = opc_cause; // RQ14
      status_cap[RS_ADR]  = adr_cause; // RQ14
      status_cap[RS_CLK]  = i_clock_gen_reset; // RQ14 RQ20
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.wdog_restart = 1'b0;
    s_d.pin_prev = i_irq_pin;
    if (i_rst) begin
      s_d.bus      = BUS_IDLE;
      s_d.rdata    = '0;
      s_d.edge_sel = 1'b0;
      s_d.pin_en   = 1'b0;
      s_d.flag     = 1'b0;
      s_d.irq_en   = 1'b0;
      s_d.mode     = 1'b0;
      s_d.pin_prev = PIN_IDLE_LEVEL;
      s_d.irq      = 1'b0;
      // Status is not cleared: it records why reset happened
      s_d.status   = status_cap; // RQ14
    end else begin
      case (s_q.bus)
        BUS_IDLE: begin
          if (req) begin
            // Read data sampled one cycle early; flag may set meanwhile
            s_d.rdata = '0;
            if (sel_ctrl) begin
              s_d.rdata[REG_W-1:0] = ctrl_image;
            end else if (sel_status) begin
              s_d.rdata[REG_W-1:0] = s_q.status; // RQ22
            end
            s_d.bus = BUS_ACK;
          end
        end
        BUS_ACK: begin
          s_d.bus = BUS_IDLE;
        end
        default: begin
          s_d.bus = BUS_IDLE;
        end
      endcase
      if (wr_ctrl) begin
        s_d.edge_sel = i_avs_writedata[PC_EDGE];
        s_d.pin_en   = i_avs_writedata[PC_PE];
        s_d.irq_en   = i_avs_writedata[PC_IE];
        s_d.mode     = i_avs_writedata[PC_MOD];
        if (i_avs_writedata[PC_ACK]) begin
          s_d.flag = 1'b0; // RQ5
        end
      end
      // Set wins over acknowledge; level keeps flag set
      if (event_hit) begin
        s_d.flag = 1'b1; // RQ4 RQ6
      end
      if (accept & i_avs_write & sel_status) begin
        s_d.wdog_restart = 1'b1; // RQ11
      end
      s_d.irq = s_d.flag & s_d.irq_en; // RQ7
    end
  end

  always_ff @(posedge i_core_clk) begin
    s_q <= s_d;
  end

  assign o_avs_readdata     = s_q.rdata;
  assign o_irq_request      = s_q.irq;
  assign o_pull_enable      = s_q.pin_en; // RQ3
  assign o_pull_down        = s_q.pin_en & s_q.edge_sel; // RQ2
  assign o_watchdog_restart = s_q.wdog_restart;
  assign o_reset_request    = i_power_on | ~i_ext_reset_pin_n | wdog_cause
                            | opc_cause | adr_cause | lvd_cause
                            | i_clock_gen_reset | i_debug_forced_reset_bit;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence ctrl_write_s;
    accept && i_avs_write && sel_ctrl && i_avs_byteenable[0];
  endsequence
  sequence status_write_s;
    accept && i_avs_write && sel_status;
  endsequence
  sequence ctrl_read_s;
    accept && i_avs_read && sel_ctrl;
  endsequence

  wait_bound_a: assert property (
    req |-> ##[0:1] !o_avs_waitrequest)
    else $error("waitrequest held too long");
  flag_set_a: assert property ( // RQ4
    event_hit |=> s_q.flag && ctrl_image[PC_FLAG])
    else $error("event did not set flag");
  ack_clear_a: assert property ( // RQ5
    (ctrl_write_s and i_avs_writedata[PC_ACK] && !event_hit)
    |=> !s_q.flag)
    else $error("acknowledge did not clear flag");
  level_hold_a: assert property ( // RQ6
    (s_q.mode && s_q.pin_en && level_hit && s_q.flag) |=> s_q.flag)
    else $error("flag cleared while level asserted");
  edge_only_a: assert property ( // RQ8
    (!s_q.mode && !edge_hit && !s_q.flag && !wr_ctrl) |=> !s_q.flag)
    else $error("flag set without an edge");
  irq_out_a: assert property ( // RQ7
    (s_q.flag && s_q.irq_en) [*2] |-> o_irq_request)
    else $error("interrupt request missing");
  irq_off_a: assert property ( // RQ7
    !s_q.irq_en |-> !o_irq_request)
    else $error("interrupt request while disabled");
  pull_dir_a: assert property ( // RQ2
    o_pull_down |-> o_pull_enable && s_q.edge_sel && s_q.pin_en)
    else $error("pull-down without enabled rising pin");
  unimpl_read_a: assert property ( // RQ9
    ctrl_read_s |-> o_avs_readdata[7:6] == 2'b00
                    && o_avs_readdata[PC_ACK] == 1'b0)
    else $error("unimplemented bits read nonzero");
  wdog_restart_a: assert property ( // RQ11
    status_write_s |=> o_watchdog_restart && $stable(s_q.status))
    else $error("status write misbehaved");
  status_keep_a: assert property ( // RQ22
    !$past(i_rst) |-> $stable(s_q.status) && !s_q.status[0])
    else $error("status changed outside reset");
  debug_clear_a: assert property ( // RQ10
    ($fell(i_rst) && $past(i_debug_forced_reset_bit))
    |-> s_q.status == STATUS_CLEAR)
    else $error("debug reset left cause bits");
  por_image_a: assert property ( // RQ12
    ($fell(i_rst) && $past(i_power_on)
     && !$past(i_debug_forced_reset_bit))
    |-> s_q.status == POR_STATUS)
    else $error("power-on image wrong");
  wdog_block_a: assert property ( // RQ16
    ($fell(i_rst) && !$past(i_watchdog_enable_setting))
    |-> !s_q.status[RS_WDOG])
    else $error("watchdog cause while disabled");

  // Cause checks at the first edge after release; the last
  // reset edge holds the sources that were captured
  sequence reset_exit_s;
    $fell(i_rst) && !$past(i_debug_forced_reset_bit)
    && !$past(i_power_on);
  endsequence
  sequence plain_exit_s;
    reset_exit_s ##0 !$past(lvd_cause);
  endsequence

  // Kept power-on bit depends on history, so it is left out here
  lvd_image_a: assert property ( // RQ13
    (reset_exit_s ##0 $past(lvd_cause))
    |-> s_q.status[RS_LVD] && !s_q.status[RS_PIN]
        && !s_q.status[RS_WDOG] && !s_q.status[RS_CLK])
    else $error("brownout image wrong");
  pin_cause_a: assert property ( // RQ15
    plain_exit_s
    |-> s_q.status[RS_PIN] == !$past(i_ext_reset_pin_n))
    else $error("pin cause wrong");
  wdog_cause_a: assert property ( // RQ16
    plain_exit_s
    |-> s_q.status[RS_WDOG] == ($past(i_watchdog_timeout)
                                && $past(i_watchdog_enable_setting)))
    else $error("watchdog cause wrong");
  opc_cause_a: assert property ( // RQ17
    plain_exit_s
    |-> s_q.status[RS_OPC] == ($past(i_illegal_opcode)
        || ($past(i_stop_instr) && !$past(i_stop_allowed_setting))
        || ($past(i_background_entry_instruction)
            && !$past(i_background_allowed_setting))))
    else $error("opcode cause wrong");
  adr_gap_a: assert property ( // RQ18
    (plain_exit_s ##0 $past(i_access_valid)
     && !$past(i_access_in_register_area)
     && $past(i_access_addr) >= GAP0_LO
     && $past(i_access_addr) <= GAP0_HI)
    |-> s_q.status[RS_ADR])
    else $error("gap access not recorded");
  adr_reg_a: assert property ( // RQ19
    (plain_exit_s ##0 $past(i_access_in_register_area))
    |-> !s_q.status[RS_ADR])
    else $error("register area access recorded");
  clk_cause_a: assert property ( // RQ20
    plain_exit_s |-> s_q.status[RS_CLK] == $past(i_clock_gen_reset))
    else $error("clock cause wrong");
  lvd_stop_a: assert property ( // RQ21
    (reset_exit_s ##0 $past(i_stop_mode)
     && !$past(i_brownout_in_stop_enable))
    |-> !s_q.status[RS_LVD])
    else $error("brownout cause in stop");

  // Pin side: configuration and event qualifiers
  pull_en_a: assert property ( // RQ3
    ctrl_write_s |=> o_pull_enable == $past(i_avs_writedata[PC_PE]))
    else $error("pull enable not stored");
  no_source_a: assert property ( // RQ3
    (!s_q.pin_en && !s_q.flag) |=> !s_q.flag)
    else $error("flag set with pin disabled");
  rise_pol_a: assert property ( // RQ1
    (s_q.pin_en && s_q.edge_sel && $rose(i_irq_pin)) |=> s_q.flag)
    else $error("rising edge missed");
  fall_pol_a: assert property ( // RQ1
    (s_q.pin_en && !s_q.edge_sel && $fell(i_irq_pin)) |=> s_q.flag)
    else $error("falling edge missed");
  ack_zero_a: assert property ( // RQ5
    (ctrl_write_s and !i_avs_writedata[PC_ACK] && s_q.flag)
    |=> s_q.flag)
    else $error("zero acknowledge cleared flag");
  mode_store_a: assert property ( // RQ8
    ctrl_write_s
    |=> s_q.mode == $past(i_avs_writedata[PC_MOD])
        && s_q.edge_sel == $past(i_avs_writedata[PC_EDGE]))
    else $error("mode or polarity not stored");
  irq_en_store_a: assert property ( // RQ7
    ctrl_write_s |=> s_q.irq_en == $past(i_avs_writedata[PC_IE]))
    else $error("interrupt enable not stored");
  unmapped_a: assert property ( // RQ9
    (accept && i_avs_write && !sel_ctrl)
    |=> $stable({s_q.edge_sel, s_q.pin_en, s_q.irq_en, s_q.mode}))
    else $error("unmapped write changed control");

endmodule

// ==== dv/pin_model.sv ====
// Purpose: Board-side model of the external request pin.
// Assumes: Bench decides when the pin is actively driven, and to what.
// Notes:   A floating pin with no pull wanders, so it toggles every cycle.
`timescale 1ns/100ps
module pin_model (
  input  wire logic i_core_clk,
  input  wire logic i_pull_enable,
  input  wire logic i_pull_down,
  input  wire logic i_drive_en,
  input  wire logic i_drive_level,
  output logic      o_pin
);
  logic wander_q = 1'b0;
  always_ff @(posedge i_core_clk) wander_q <= ~wander_q;
  // Pulled pin settles to the pull level, never a stale value
  always_comb begin
    if (i_drive_en)
      o_pin = i_drive_level;
    else if (i_pull_enable)
      o_pin = ~i_pull_down;
    else
      o_pin = wander_q;
  end
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the pin request and reset cause block.
// Assumes: Bench is the only bus master; accesses wait on waitrequest.
// Notes:   Reset table order matters, so kept bits become visible.
`timescale 1ns/100ps
module tb_top
  import irq_rst_pkg::*;
();
  logic        clk           = 1'b0;
  logic        rst           = 1'b1;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        drv_en        = 1'b0;
  logic        drv_lvl       = 1'b0;
  logic [17:0] src           = 18'h00001;
  logic [15:0] acc_addr      = 16'h0000;
  logic [31:0] rdata;
  logic        wait_req, irq_req, pull_en, pull_dn, wd_restart, pin;
  logic        rst_req;
  int          miscompares   = 0;
  int          checks_done   = 0;
  localparam logic [17:0] RSRC [20] = '{18'h00001, 18'h0D000, 18'h00002,
    18'h0D000, 18'h00004, 18'h0000C, 18'h00010, 18'h00020, 18'h00060,
    18'h00080, 18'h00200, 18'h00600, 18'h00200, 18'h00200, 18'h00200,
    18'h00200, 18'h00800, 18'h20002, 18'h0F000, 18'h1F000};
  localparam logic [19:0] RREQ = 20'hB56EF;
  localparam logic [15:0] RADR [20] = '{16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0880, 16'h0880, 16'h17FF, 16'h1800, 16'h182C, 16'hC000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000};
  localparam logic [7:0] REXP [20] = '{8'h82, 8'h82, 8'h40, 8'h02, 8'h00,
    8'h20, 8'h10, 8'h10, 8'h00, 8'h10, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h00, 8'h04, 8'h00, 8'h00, 8'h02};

  irq_pin_and_reset_status dut_u (
    .i_core_clk                     (clk),
    .i_rst                          (rst),
    .i_avs_address                  (avs_address),
    .i_avs_read                     (avs_read),
    .i_avs_write                    (avs_write),
    .i_avs_writedata                (avs_writedata),
    .i_avs_byteenable               (4'hF),
    .o_avs_readdata                 (rdata),
    .o_avs_waitrequest              (wait_req),
    .i_irq_pin                      (pin),
    .o_irq_request                  (irq_req),
    .o_pull_enable                  (pull_en),
    .o_pull_down                    (pull_dn),
    .o_watchdog_restart             (wd_restart),
    .o_reset_request                (rst_req),
    .i_power_on                     (src[0]),
    .i_ext_reset_pin_n              (~src[1]),
    .i_watchdog_timeout             (src[2]),
    .i_watchdog_enable_setting      (src[3]),
    .i_illegal_opcode               (src[4]),
    .i_stop_instr                   (src[5]),
    .i_stop_allowed_setting         (src[6]),
    .i_background_entry_instruction (src[7]),
    .i_background_allowed_setting   (src[8]),
    .i_access_valid                 (src[9]),
    .i_access_addr                  (acc_addr),
    .i_access_in_register_area      (src[10]),
    .i_clock_gen_reset              (src[11]),
    .i_supply_low                   (src[12]),
    .i_stop_mode                    (src[13]),
    .i_brownout_detect_enable       (src[14]),
    .i_brownout_reset_enable        (src[15]),
    .i_brownout_in_stop_enable      (src[16]),
    .i_debug_forced_reset_bit       (src[17])
  );
  pin_model pin_u (
    .i_core_clk    (clk),
    .i_pull_enable (pull_en),
    .i_pull_down   (pull_dn),
    .i_drive_en    (drv_en),
    .i_drive_level (drv_lvl),
    .o_pin         (pin)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus_go(input logic [3:0] a, input logic rd,
                        input logic [7:0] d, output logic [31:0] rq);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_read      <= rd;
    avs_write     <= ~rd;
    // Values seen here are those the slave sampled at this edge
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    rq = rdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] rq;
    bus_go(a, 1'b0, d, rq);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] rq;
    bus_go(a, 1'b1, 8'h00, rq);
    chk("readdata", rq, {24'h000000, e});
  endtask
  task automatic drive(input logic e, input logic l);
    @(posedge clk);
    drv_en  <= e;
    drv_lvl <= l;
    repeat (3) @(posedge clk);
  endtask
  task automatic do_rst(input logic [17:0] s, input logic [15:0] a,
                        input logic e);
    @(posedge clk);
    src      <= s;
    acc_addr <= a;
    rst      <= 1'b1;
    @(negedge clk);
    chk("reset_req", rst_req, e);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    src <= 18'h00000;
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    src <= 18'h00000;
    rd(OFS_RESET_STATUS, 8'h82);
    rd(OFS_PIN_CTRL, 8'h00);
    wr(OFS_RESET_STATUS, 8'hFF);
    @(negedge clk);
    chk("restart", wd_restart, 1'b1);
    @(negedge clk);
    chk("restart", wd_restart, 1'b0);
    rd(OFS_RESET_STATUS, 8'h82);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h00);
    rd(OFS_PIN_CTRL, 8'h00);
    drive(1'b1, 1'b0);
    wr(OFS_PIN_CTRL, 8'hFF);
    drive(1'b0, 1'b0);
    chk("pull_en", pull_en, 1'b1);
    chk("pull_dn", pull_dn, 1'b1);
    rd(OFS_PIN_CTRL, 8'h33);
    drive(1'b1, 1'b1);
    rd(OFS_PIN_CTRL, 8'h3B);
    chk("irq", irq_req, 1'b1);
    wr(OFS_PIN_CTRL, 8'h33);
    rd(OFS_PIN_CTRL, 8'h3B);
    wr(OFS_PIN_CTRL, 8'h37);
    rd(OFS_PIN_CTRL, 8'h3B);
    drive(1'b1, 1'b0);
    wr(OFS_PIN_CTRL, 8'h37);
    rd(OFS_PIN_CTRL, 8'h33);
    chk("irq", irq_req, 1'b0);
    drive(1'b1, 1'b1);
    wr(OFS_PIN_CTRL, 8'h10);
    wr(OFS_PIN_CTRL, 8'h14);
    chk("pull_dn", pull_dn, 1'b0);
    rd(OFS_PIN_CTRL, 8'h10);
    drive(1'b1, 1'b0);
    rd(OFS_PIN_CTRL, 8'h18);
    chk("irq", irq_req, 1'b0);
    wr(OFS_PIN_CTRL, 8'h14);
    rd(OFS_PIN_CTRL, 8'h10);
    wr(OFS_PIN_CTRL, 8'h12);
    rd(OFS_PIN_CTRL, 8'h12);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    rd(OFS_PIN_CTRL, 8'h1A);
    chk("irq", irq_req, 1'b1);
    wr(OFS_PIN_CTRL, 8'h16);
    rd(OFS_PIN_CTRL, 8'h12);
    wr(OFS_PIN_CTRL, 8'h02);
    drive(1'b0, 1'b0);
    rd(OFS_PIN_CTRL, 8'h02);
    chk("pull_en", pull_en, 1'b0);
    for (int k = 0; k < 20; k++) begin
      do_rst(RSRC[k], RADR[k], RREQ[k]);
      rd(OFS_RESET_STATUS, REXP[k]);
    end
    rd(OFS_PIN_CTRL, 8'h00);
    stop_test();
  end
endmodule
